/* hdl/sbsw_pkg.sv */
// Purpose: Shared constants and types for the standby, sleep and watchdog
//          supervisor.
// Assumes: A 100 MHz reference clock; speed commands in Q15 or in hertz.
// Notes:   All thresholds, detection times and watchdog intervals live here; reset values are set in the supervisor.

package sbsw_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int CLK_MHZ = 100;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYC_DEF = MS_TIME_US * CLK_MHZ;

  // ==========================================================================
  // Speed thresholds
  // ==========================================================================
  localparam logic [15:0] Q15_FULL = 16'h7FFF;
  localparam logic [15:0] PCT1_Q15 = 16'(32767 * 1 / 100);
  localparam logic [15:0] ANA_ENTRY_Q15 = 16'(32767 * 1 / 100);
  localparam logic [15:0] ANA_EXIT_Q15 = 16'(32767 * 5 / 100);
  localparam logic [15:0] FREQ_MIN_HZ = 16'h0003;
  localparam int Q15_SHIFT = 15;

  // ==========================================================================
  // Detection times and watchdog intervals in milliseconds
  // ==========================================================================
  localparam logic [7:0] SLEEP_DET_MS = 8'h14;
  localparam logic [7:0] WAKE_DET_MS = 8'h14;
  localparam logic [13:0] WD_PIN_MS0 = 14'h0064;
  localparam logic [13:0] WD_PIN_MS1 = 14'h00C8;
  localparam logic [13:0] WD_PIN_MS2 = 14'h01F4;
  localparam logic [13:0] WD_PIN_MS3 = 14'h03E8;
  localparam logic [13:0] WD_I2C_MS0 = 14'h03E8;
  localparam logic [13:0] WD_I2C_MS1 = 14'h07D0;
  localparam logic [13:0] WD_I2C_MS2 = 14'h1388;
  localparam logic [13:0] WD_I2C_MS3 = 14'h2710;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    SRC_ANALOG = 2'h0,
    SRC_PWM = 2'h1,
    SRC_I2C = 2'h2,
    SRC_FREQ = 2'h3
  } sbsw_src_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_STBY = 2'h1,
    ST_SLEEP = 2'h3
  } sbsw_state_t;

  typedef struct packed {
    sbsw_src_t speed_mode;
    logic [1:0] ref_profile_cfg;
    logic [15:0] duty_hysteresis;
    logic [15:0] input_max_freq;
    logic low_power_state_select;
  } sbsw_spd_cfg_t;

  typedef struct packed {
    logic watchdog_enable_bit;
    logic watchdog_source_select;
    logic [1:0] watchdog_timeout_select;
    logic watchdog_response_select;
  } sbsw_wdt_cfg_t;

  typedef struct packed {
    logic [15:0] entry;
    logic [15:0] exit_lvl;
  } sbsw_thr_t;

endpackage : sbsw_pkg

/* hdl/sbsw_supervisor.sv */
// Purpose: Standby and sleep control, latched faults, output disable and
//          external watchdog of a sensorless motor driver.
// Assumes: Speed command and fault condition come from logic on ref_clk_i;
//          the three pins are asynchronous and are synchronised here.
// Notes:   All outputs are registered fields of the state struct.
//
// How it works
// - Standby follows per-source entry and exit thresholds.
// - Analog standby at 1% entry, 5% exit.
// - PWM threshold max(1%, hysteresis), else 0%.
// - I2C threshold max(1%, hysteresis) scaled 32767, else 0%.
// - Frequency threshold scaled, never below 3Hz.
// - Pin low sleeps, pin high wakes, timed.
// - Latched fault holds until cleared and gone.
// - Output-disable pin forces all switches off.
// - Watchdog faults only while enable bit set.
// - Tickle is pin rising edge or I2C bit.
// - Fault when tickle interval exceeds timeout.
// - Response either reports or latches with Hi-Z.
// - Clear-fault bit clears latched watchdog fault.
// - Timeout sets watchdog fault status bit.
// - Timely tickle restarts the watchdog timer.
// - Source select picks pin or I2C tickles.
// - Pin timeouts 100, 200, 500, 1000ms.
// - I2C timeouts 1, 2, 5, 10s.
// - Mode bit picks sleep or standby.
// - Sleep gates supplies; standby keeps them on.

`timescale 1ns/1ps

module sbsw_supervisor
  import sbsw_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire sbsw_spd_cfg_t spd_cfg_i,
  input wire logic [15:0] speed_cmd_i,
  input wire logic speed_pin_i,
  input wire logic output_disable_pin_i,
  input wire logic clear_fault_bit_i,
  input wire logic fault_cond_i,
  input wire sbsw_wdt_cfg_t wdt_cfg_i,
  input wire logic watchdog_tickle_pin_i,
  input wire logic i2c_tickle_bit_i,
  output logic sw_hiz_o,
  output logic standby_o,
  output logic sleep_o,
  output logic supply_en_o,
  output logic sense_en_o,
  output logic watchdog_fault_o,
  output logic watchdog_latched_o,
  output logic fault_latched_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic drv_s1;
    logic drv_s2;
    logic spd_s1;
    logic spd_s2;
    logic tck_s1;
    logic tck_s2;
    logic tck_prev;
    logic wd_en_prev;
    logic [16:0] ms_cnt;
    logic [13:0] wd_ms;
    logic [7:0] det_ms;
    sbsw_state_t state;
    logic wd_fault;
    logic wd_lat;
    logic flt_lat;
    logic hiz;
    logic stby;
    logic sleep;
    logic supply_en;
    logic sense_en;
  } sbsw_reg_t;

  sbsw_reg_t q;
  sbsw_reg_t d;
  sbsw_thr_t thr;
  logic ms_tick;
  logic tickle;
  logic en_rise;
  logic expire;
  logic use_sleep;
  logic [13:0] limit;
  sbsw_state_t low_state;

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic logic [15:0] max16_f(input logic [15:0] a,
                                          input logic [15:0] b);
    max16_f = (a > b) ? a : b;
  endfunction : max16_f

  function automatic sbsw_thr_t thr_f(input sbsw_spd_cfg_t c);
    logic [15:0] hys;
    logic [31:0] prod;
    logic prof0;
    hys = max16_f(PCT1_Q15, c.duty_hysteresis);
    prod = 32'(hys) * 32'(c.input_max_freq);
    prof0 = (c.ref_profile_cfg == 2'h0);
    thr_f = '0;
    case (c.speed_mode)
      SRC_ANALOG: begin
        thr_f.entry = ANA_ENTRY_Q15;
        thr_f.exit_lvl = ANA_EXIT_Q15;
      end
      SRC_PWM, SRC_I2C: begin
        thr_f.entry = prof0 ? hys : 16'h0000;
        thr_f.exit_lvl = prof0 ? hys : 16'h0000;
      end
      SRC_FREQ: begin
        thr_f.entry = prof0 ?
          max16_f(FREQ_MIN_HZ, prod[Q15_SHIFT +: 16]) : FREQ_MIN_HZ;
        thr_f.exit_lvl = thr_f.entry;
      end
      default: thr_f = '0;
    endcase
  endfunction : thr_f

  function automatic logic [13:0] wd_limit_f(input logic i2c_src,
                                             input logic [1:0] sel);
    case (sel)
      2'h0: wd_limit_f = i2c_src ? WD_I2C_MS0 : WD_PIN_MS0;
      2'h1: wd_limit_f = i2c_src ? WD_I2C_MS1 : WD_PIN_MS1;
      2'h2: wd_limit_f = i2c_src ? WD_I2C_MS2 : WD_PIN_MS2;
      default: wd_limit_f = i2c_src ? WD_I2C_MS3 : WD_PIN_MS3;
    endcase
  endfunction : wd_limit_f

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d = q;
    d.drv_s1 = output_disable_pin_i;
    d.drv_s2 = q.drv_s1;
    d.spd_s1 = speed_pin_i;
    d.spd_s2 = q.spd_s1;
    d.tck_s1 = watchdog_tickle_pin_i;
    d.tck_s2 = q.tck_s1;
    d.tck_prev = q.tck_s2;
    d.wd_en_prev = wdt_cfg_i.watchdog_enable_bit;

    ms_tick = (q.ms_cnt == 17'(MS_CYC - 1));
    d.ms_cnt = ms_tick ? 17'h00000 : q.ms_cnt + 17'h00001;

    tickle = wdt_cfg_i.watchdog_source_select ? i2c_tickle_bit_i :
             (q.tck_s2 & ~q.tck_prev);
    en_rise = wdt_cfg_i.watchdog_enable_bit & ~q.wd_en_prev;
    limit = wd_limit_f(wdt_cfg_i.watchdog_source_select,
                       wdt_cfg_i.watchdog_timeout_select);
    expire = wdt_cfg_i.watchdog_enable_bit & ~en_rise & ~tickle &
             ms_tick & (q.wd_ms >= limit);

    if (!wdt_cfg_i.watchdog_enable_bit || en_rise || tickle || expire) begin
      d.wd_ms = 14'h0000;
    end else if (ms_tick) begin
      d.wd_ms = q.wd_ms + 14'h0001;
    end

    if (clear_fault_bit_i) begin
      d.wd_fault = 1'b0;
    end
    if (expire) begin
      d.wd_fault = 1'b1;
    end

    if (clear_fault_bit_i) begin
      d.wd_lat = 1'b0;
    end
    if (expire && wdt_cfg_i.watchdog_response_select) begin
      d.wd_lat = 1'b1;
    end

    if (clear_fault_bit_i && !fault_cond_i) begin
      d.flt_lat = 1'b0;
    end
    if (fault_cond_i) begin
      d.flt_lat = 1'b1;
    end

    thr = thr_f(spd_cfg_i);
    use_sleep = spd_cfg_i.low_power_state_select &
                ((spd_cfg_i.speed_mode == SRC_PWM) ||
                 (spd_cfg_i.speed_mode == SRC_FREQ));
    low_state = spd_cfg_i.low_power_state_select ? ST_SLEEP : ST_STBY;
    case (q.state)
      ST_RUN: begin
        if (use_sleep) begin
          if (q.spd_s2) begin
            d.det_ms = 8'h00;
          end else if (q.det_ms >= SLEEP_DET_MS) begin
            d.det_ms = 8'h00;
            d.state = ST_SLEEP;
          end else if (ms_tick) begin
            d.det_ms = q.det_ms + 8'h01;
          end
        end else if (speed_cmd_i < thr.entry) begin
          d.det_ms = 8'h00;
          d.state = low_state;
        end
      end
      ST_STBY: begin
        d.det_ms = 8'h00;
        if (speed_cmd_i > thr.exit_lvl) begin
          d.state = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (use_sleep) begin
          if (!q.spd_s2) begin
            d.det_ms = 8'h00;
          end else if (q.det_ms >= WAKE_DET_MS) begin
            d.det_ms = 8'h00;
            d.state = ST_RUN;
          end else if (ms_tick) begin
            d.det_ms = q.det_ms + 8'h01;
          end
        end else if (speed_cmd_i > thr.exit_lvl) begin
          d.det_ms = 8'h00;
          d.state = ST_RUN;
        end
      end
      default: begin
        d.det_ms = 8'h00;
        d.state = ST_RUN;
      end
    endcase

    d.stby = (d.state == ST_STBY);
    d.sleep = (d.state == ST_SLEEP);
    d.supply_en = (d.state != ST_SLEEP);
    d.sense_en = (d.state == ST_RUN);
    d.hiz = q.drv_s2 | d.flt_lat | d.wd_lat | (d.state != ST_RUN);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.hiz <= 1'b1;
      q.supply_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sw_hiz_o = q.hiz;
  assign standby_o = q.stby;
  assign sleep_o = q.sleep;
  assign supply_en_o = q.supply_en;
  assign sense_en_o = q.sense_en;
  assign watchdog_fault_o = q.wd_fault;
  assign watchdog_latched_o = q.wd_lat;
  assign fault_latched_o = q.flt_lat;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_drv_hiz;
    q.drv_s2 |=> sw_hiz_o;
  endproperty
  a_drv_hiz: assert property (p_drv_hiz)
    else $error("Output disable did not force Hi-Z.");
  property p_wd_needs_en;
    $rose(watchdog_fault_o) |-> $past(wdt_cfg_i.watchdog_enable_bit);
  endproperty
  a_wd_needs_en: assert property (p_wd_needs_en)
    else $error("Watchdog fault raised while disabled.");
  property p_wd_expire;
    (wdt_cfg_i.watchdog_enable_bit && !en_rise && !tickle && ms_tick &&
     q.wd_ms >= limit) |=> watchdog_fault_o && q.wd_ms == 14'h0000;
  endproperty
  a_wd_expire: assert property (p_wd_expire)
    else $error("Watchdog timeout did not set fault.");
  property p_tickle_restart;
    (wdt_cfg_i.watchdog_enable_bit && tickle) |=> q.wd_ms == 14'h0000;
  endproperty
  a_tickle_restart: assert property (p_tickle_restart)
    else $error("Tickle did not restart watchdog timer.");
  property p_wd_clear;
    (clear_fault_bit_i && !expire) |=> !watchdog_latched_o;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("Clear did not release watchdog latch.");

  property p_wd_latch_mode;
    $rose(watchdog_latched_o) |->
      $past(wdt_cfg_i.watchdog_response_select) && watchdog_fault_o &&
      sw_hiz_o;
  endproperty
  a_wd_latch_mode: assert property (p_wd_latch_mode)
    else $error("Watchdog latch in report mode or without Hi-Z.");

  property p_flt_hold;
    (fault_latched_o && fault_cond_i) |=> fault_latched_o && sw_hiz_o;
  endproperty
  a_flt_hold: assert property (p_flt_hold)
    else $error("Latched fault released while condition present.");

  property p_ana_entry;
    (q.state == ST_RUN && spd_cfg_i.speed_mode == SRC_ANALOG &&
     !spd_cfg_i.low_power_state_select && speed_cmd_i < ANA_ENTRY_Q15)
      |=> standby_o && supply_en_o;
  endproperty
  a_ana_entry: assert property (p_ana_entry)
    else $error("Analog command below entry did not give standby.");

  property p_sleep_low;
    $rose(sleep_o) && !$past(q.state == ST_STBY) && $past(use_sleep)
      |-> !$past(q.spd_s2) && !supply_en_o;
  endproperty
  a_sleep_low: assert property (p_sleep_low)
    else $error("Sleep entered with speed pin high.");

  property p_en_restart;
    $rose(wdt_cfg_i.watchdog_enable_bit) |=> q.wd_ms == 14'h0000;
  endproperty
  a_en_restart: assert property (p_en_restart)
    else $error("Watchdog timer not restarted on enable.");

  c_wd_fault: cover property ($rose(watchdog_fault_o));
  c_sleep: cover property ($rose(sleep_o) ##[1:1000] $fell(sleep_o));
  c_standby: cover property ($rose(standby_o));
  c_latched: cover property ($rose(watchdog_latched_o));

endmodule : sbsw_supervisor

/* sim/sbsw_host_model.sv */
// Purpose: Host controller model that drives the supervisor's pins.
// Assumes: Tasks are entered just after a rising edge of ref_clk_i.
// Notes:   Output disable is released only after its minimum hold.

`timescale 1ns/1ps

module sbsw_host_model #(
  parameter int ODIS_HOLD = 40
) (
  input wire logic ref_clk_i,
  output logic tickle_pin_o,
  output logic i2c_tickle_o,
  output logic odis_pin_o,
  output logic speed_pin_o
);
  int hold_cnt;

  initial begin
    tickle_pin_o = 1'b0;
    i2c_tickle_o = 1'b0;
    odis_pin_o = 1'b0;
    speed_pin_o = 1'b1;
    hold_cnt = 0;
  end

  always @(posedge ref_clk_i) begin
    if (odis_pin_o) begin
      hold_cnt <= hold_cnt + 1;
    end
  end

  task automatic tickle_pin();
    tickle_pin_o = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    tickle_pin_o = 1'b0;
  endtask : tickle_pin

  task automatic tickle_i2c();
    i2c_tickle_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    i2c_tickle_o = 1'b0;
  endtask : tickle_i2c

  task automatic set_odis(logic v);
    if (v) begin
      hold_cnt = 0;
    end else begin
      while (hold_cnt < ODIS_HOLD) @(posedge ref_clk_i);
      #1;
    end
    odis_pin_o = v;
  endtask : set_odis

  task automatic set_speed_pin(logic v);
    speed_pin_o = v;
  endtask : set_speed_pin
endmodule : sbsw_host_model

/* sim/test_standby_sleep_watchdog_supervisor.sv */
// Purpose: Self-checking bench of the standby, sleep and watchdog block.
// Assumes: A shortened millisecond of MS cycles.
// Notes:   Expected outputs are queued and compared by a monitor.

`timescale 1ns/1ps

module test_standby_sleep_watchdog_supervisor;
  import sbsw_pkg::*;
  localparam int MS = 10;
  localparam logic [7:0] HIZ = 8'h80, SB = 8'h40, SL = 8'h20, SUP = 8'h10;
  localparam logic [7:0] SEN = 8'h08, WF = 8'h04, WL = 8'h02, FL = 8'h01;
  logic ref_clk, nrst, clr, fcond;
  logic tk_pin, tk_i2c, odis, spin;
  logic [15:0] cmd;
  sbsw_spd_cfg_t spd;
  sbsw_wdt_cfg_t wdt;
  wire logic [7:0] obs;
  logic [15:0] q[$];
  logic [15:0] e;
  logic [15:0] lfsr_q = 16'h0057;
  int fails = 0;
  int cmp_count = 0;
  int lim_pin[4] = '{100, 200, 500, 1000};

  // ==========================================================================
  // Design and host
  // ==========================================================================
  sbsw_supervisor #(.MS_CYC(MS)) uut (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .spd_cfg_i(spd),
    .speed_cmd_i(cmd), .speed_pin_i(spin), .output_disable_pin_i(odis),
    .clear_fault_bit_i(clr), .fault_cond_i(fcond), .wdt_cfg_i(wdt),
    .watchdog_tickle_pin_i(tk_pin), .i2c_tickle_bit_i(tk_i2c),
    .sw_hiz_o(obs[7]), .standby_o(obs[6]), .sleep_o(obs[5]),
    .supply_en_o(obs[4]), .sense_en_o(obs[3]),
    .watchdog_fault_o(obs[2]), .watchdog_latched_o(obs[1]),
    .fault_latched_o(obs[0])
  );

  sbsw_host_model #(.ODIS_HOLD(40)) host (
    .ref_clk_i(ref_clk), .tickle_pin_o(tk_pin), .i2c_tickle_o(tk_i2c),
    .odis_pin_o(odis), .speed_pin_o(spin)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] lfsr_next();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : lfsr_next

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic note(logic [7:0] m, logic [7:0] v);
    q.push_back({m, v & m});
  endtask : note

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic wait_bit(logic [7:0] m, logic [7:0] v, int max);
    int n;
    n = 0;
    while ((obs & m) !== (v & m) && n < max) begin
      step(1);
      n++;
    end
    if ((obs & m) !== (v & m)) begin
      check("wait", obs & m, v & m);
      end_of_test();
    end
  endtask : wait_bit

  task automatic pulse_clr();
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(1);
  endtask : pulse_clr

  task automatic std_case(sbsw_src_t s, logic [1:0] p, logic [15:0] h,
                          logic [15:0] mf, logic [15:0] en, logic [15:0] ex);
    spd = '{s, p, h, mf, 1'b0};
    cmd = ex + (lfsr_next() & 16'h003F) + 16'h0001;
    step(1);
    note(SB | HIZ | SEN, SEN); // above exit runs.
    cmd = en;
    step(1);
    note(SB, 8'h00); // equal entry holds.
    if (en != 16'h0000) begin
      cmd = en - 16'h0001;
      step(1);
      note(SB | SL | HIZ | SEN | SUP, SB | HIZ | SUP); // standby.
      cmd = ex;
      step(1);
      note(SB, SB); // equal exit holds.
      cmd = ex + 16'h0001;
      step(1);
      note(SB | HIZ | SEN, SEN); // exit standby.
    end
  endtask : std_case

  task automatic wd_case(logic src, logic [1:0] sel, int lim);
    int t;
    t = lim * MS;
    wdt = '{1'b0, src, sel, sel[0]}; // change while disabled.
    step(2);
    wdt.watchdog_enable_bit = 1'b1;
    repeat (3) begin
      step(t / 2 + int'(lfsr_next() & 16'h003F));
      if (src) host.tickle_i2c();
      else host.tickle_pin();
    end
    note(WF, 8'h00); // timely tickles restart.
    if (src) begin
      repeat (4) begin
        step(t / 8);
        host.tickle_pin();
      end
      step(t / 2 - 52);
    end else begin
      step(t - 20);
    end
    note(WF, 8'h00); // no early fault.
    wait_bit(WF, WF, 60);
    note(WF | WL | HIZ, sel[0] ? (WF | WL | HIZ) : WF);
    pulse_clr();
    note(WF | WL | HIZ, 8'h00); // clear latched fault.
    wdt.watchdog_enable_bit = 1'b0;
    step(t + 40);
    note(WF, 8'h00); // disabled never faults.
  endtask : wd_case

  // ==========================================================================
  // Monitor
  // ==========================================================================
  initial begin
    forever begin
      @(posedge ref_clk);
      #2;
      while (q.size() > 0) begin
        e = q.pop_front();
        check("outputs", obs & e[15:8], e[7:0]);
      end
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    nrst = 1'b0;
    clr = 1'b0;
    fcond = 1'b0;
    cmd = 16'h07D0;
    spd = '{SRC_ANALOG, 2'h0, 16'h0000, 16'h03E8, 1'b0};
    wdt = '0;
    step(4);
    note(8'hFF, HIZ | SUP); // reset levels.
    step(4);
    nrst = 1'b1;
    step(2);
    note(8'hFF, SUP | SEN); // run after reset.
    std_case(SRC_ANALOG, 2'h2, 16'h0000, 16'h0000, 16'd327, 16'd1638);
    std_case(SRC_PWM, 2'h0, 16'h03E8, 16'h0000, 16'd1000, 16'd1000);
    std_case(SRC_PWM, 2'h0, 16'h0064, 16'h0000, 16'd327, 16'd327);
    std_case(SRC_PWM, 2'h1, 16'h03E8, 16'h0000, 16'd0, 16'd0);
    std_case(SRC_I2C, 2'h0, 16'h0800, 16'h0000, 16'd2048, 16'd2048);
    std_case(SRC_I2C, 2'h3, 16'h0800, 16'h0000, 16'd0, 16'd0);
    std_case(SRC_FREQ, 2'h0, 16'h0000, 16'h03E8, 16'd9, 16'd9);
    std_case(SRC_FREQ, 2'h0, 16'h4000, 16'h0064, 16'd50, 16'd50);
    std_case(SRC_FREQ, 2'h0, 16'h0000, 16'h0064, 16'd3, 16'd3);
    std_case(SRC_FREQ, 2'h1, 16'h0000, 16'h0064, 16'd3, 16'd3);
    spd = '{SRC_ANALOG, 2'h0, 16'h0000, 16'h0000, 1'b1};
    cmd = 16'd326;
    step(1);
    note(SL | SB | SUP | SEN | HIZ, SL | HIZ); // analog sleep select.
    cmd = 16'd1639;
    step(1);
    note(SL | SUP | SEN | HIZ, SUP | SEN); // threshold wake.
    spd = '{SRC_PWM, 2'h0, 16'h0000, 16'h0000, 1'b1};
    cmd = 16'h4000;
    host.set_speed_pin(1'b0);
    step(150);
    note(SL | SUP, SUP); // no early sleep.
    wait_bit(SL, SL, 100);
    note(SL | SB | SUP | SEN | HIZ, SL | HIZ); // sleep gates.
    host.set_speed_pin(1'b1);
    step(150);
    note(SL, SL); // no early wake.
    wait_bit(SL, 8'h00, 100);
    note(SL | SUP | SEN, SUP | SEN); // wake restores.
    spd = '{SRC_ANALOG, 2'h0, 16'h0000, 16'h03E8, 1'b0};
    cmd = 16'h07D0;
    host.set_odis(1'b1);
    step(2);
    note(HIZ, 8'h00); // sync latency.
    step(1);
    note(HIZ, HIZ); // outputs off.
    host.set_odis(1'b0);
    step(3);
    note(HIZ, 8'h00); // release.
    fcond = 1'b1;
    step(1);
    note(FL | HIZ, FL | HIZ); // latch and shut down.
    pulse_clr();
    note(FL, FL); // condition still present.
    fcond = 1'b0;
    step(3);
    note(FL | HIZ, FL | HIZ); // held without clear.
    pulse_clr();
    note(FL | HIZ, 8'h00); // cleared.
    for (int s = 0; s < 4; s++) begin
      wd_case(1'b0, 2'(s), lim_pin[s]); // pin intervals.
    end
    wd_case(1'b1, 2'h0, 1000); // I2C interval.
    step(5);
    end_of_test();
  end
endmodule : test_standby_sleep_watchdog_supervisor
